// *** inc/psc_pkg.sv ***
package psc_pkg;

    // Core clock and derived power-on reset length
    localparam int unsigned CLK_FREQ_HZ  = 20_000_000;
    localparam int unsigned POR_TIME_MS  = 100;
    localparam int unsigned POR_CYCLES   =
        CLK_FREQ_HZ / 1000 * POR_TIME_MS;
    localparam int unsigned POR_CNT_W    = 21;

    // Initialization clocks after completion rises
    localparam int unsigned INIT_CYCLES  = 299;
    localparam int unsigned INIT_CNT_W   = 9;

    // Bitstream framing: bytes per device, last one is an XOR check
    localparam int unsigned BYTE_BITS    = 8;
    localparam int unsigned BIT_CNT_W    = 3;
    localparam int unsigned STREAM_BYTES = 16;
    localparam int unsigned BYTE_CNT_W   = 5;
    localparam logic [7:0]  CHECK_OK     = 8'h00;

    // Synchroniser input positions in the core domain
    localparam int unsigned SY_REQ_N     = 0;
    localparam int unsigned SY_STATUS    = 1;
    localparam int unsigned SY_COMPLETE  = 2;
    localparam int unsigned SY_CHAIN_N   = 3;
    localparam int unsigned SY_TOGGLE    = 4;
    localparam int unsigned SY_W         = 5;

    typedef logic [BYTE_BITS-1:0] psc_byte_t;

    typedef enum logic [2:0] {
        ST_POR,
        ST_RESET,
        ST_CONFIG,
        ST_INIT,
        ST_USER,
        ST_ERROR
    } psc_state_e;

endpackage

// *** design/psc_sync.sv ***
module psc_sync #(
    parameter int unsigned W = 1
) (
    // Destination clock
    input  wire logic         clk,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    genvar i;

    // Two flops per bit; the first is read by the second only
    for (i = 0; i < W; i++) begin : g_bit
        logic meta_q;
        logic hold_q;
        always_ff @(posedge clk) begin
            meta_q <= async_in[i];
            hold_q <= meta_q;
        end
        assign sync_out[i] = hold_q;
    end

endmodule

// *** design/psc_shift.sv ***
module psc_shift (
    // Link clock from the host
    input  wire logic             config_serial_clock,
    input  wire logic             serial_config_data,
    // Level from the core domain, synchronised here
    input  wire logic             link_enable,
    // Assembled byte and its toggle event toward the core
    output psc_pkg::psc_byte_t    byte_q,
    output logic                  byte_toggle_q
);

    logic                              enable_s;
    logic [psc_pkg::BIT_CNT_W-1:0]     bit_cnt_q;
    logic [psc_pkg::BIT_CNT_W-1:0]     bit_cnt_d;
    psc_pkg::psc_byte_t                shift_q;
    psc_pkg::psc_byte_t                shift_d;
    psc_pkg::psc_byte_t                byte_d;
    logic                              byte_toggle_d;

    psc_sync #(.W(1)) u_en_sync (
        .clk      (config_serial_clock),
        .async_in (link_enable),
        .sync_out (enable_s)
    );

    // One bit per serial clock, first bit lands in bit 0
    always_comb begin
        bit_cnt_d     = bit_cnt_q;
        shift_d       = shift_q;
        byte_d        = byte_q;
        byte_toggle_d = byte_toggle_q;
        if (!enable_s) begin
            // Idle clocks clear the framing; no reset exists here
            bit_cnt_d     = '0;
            shift_d       = '0;
            byte_toggle_d = 1'b0;
        end else begin
            shift_d   = {serial_config_data, shift_q[7:1]};
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
                // Byte stays stable for 8 link clocks while core samples
                byte_d        = shift_d;
                byte_toggle_d = ~byte_toggle_q;
            end
        end
    end

    always_ff @(posedge config_serial_clock) begin
        bit_cnt_q     <= bit_cnt_d;
        shift_q       <= shift_d;
        byte_q        <= byte_d;
        byte_toggle_q <= byte_toggle_d;
    end

endmodule

// *** design/psc_loader.sv ***
module psc_loader #(
    // Power-on reset length in core clocks; shorten for simulation
    parameter int unsigned POR_CYCLES = psc_pkg::POR_CYCLES
) (
    // Core clock and reset
    input  wire logic          clk,
    input  wire logic          srst,

    // Serial link from the host
    input  wire logic          config_serial_clock,
    input  wire logic          serial_config_data,

    // Configuration request from the host
    input  wire logic          config_request_n,

    // Shared open-drain status line
    input  wire logic          config_status_n_i,
    output logic               config_status_n_o,
    output logic               config_status_n_oe,

    // Shared open-drain completion line
    input  wire logic          config_complete_i,
    output logic               config_complete_o,
    output logic               config_complete_oe,

    // Chain enable in and out
    input  wire logic          chain_enable_in_n,
    output logic               chain_enable_out_n,

    // Loaded data toward the device fabric
    output psc_pkg::psc_byte_t config_data,
    output logic               config_data_valid,

    // User I/O output enable and error indication
    output logic               user_io_enable,
    output logic               config_error
);

    // Cross-domain wires
    logic [psc_pkg::SY_W-1:0]  sync_in;
    logic [psc_pkg::SY_W-1:0]  sync_s;
    psc_pkg::psc_byte_t        link_byte;
    logic                      link_toggle;

    logic                      req_n_s;
    logic                      status_s;
    logic                      complete_s;
    logic                      chain_n_s;
    logic                      toggle_s;
    logic                      new_byte;
    psc_pkg::psc_byte_t        check;

    // Sequencer state
    psc_pkg::psc_state_e       state_q;
    psc_pkg::psc_state_e       state_d;
    logic [psc_pkg::POR_CNT_W-1:0]  por_cnt_q;
    logic [psc_pkg::POR_CNT_W-1:0]  por_cnt_d;
    logic [psc_pkg::INIT_CNT_W-1:0] init_cnt_q;
    logic [psc_pkg::INIT_CNT_W-1:0] init_cnt_d;
    logic [psc_pkg::BYTE_CNT_W-1:0] byte_cnt_q;
    logic [psc_pkg::BYTE_CNT_W-1:0] byte_cnt_d;
    psc_pkg::psc_byte_t        xor_q;
    psc_pkg::psc_byte_t        xor_d;
    logic                      toggle_seen_q;
    logic                      toggle_seen_d;
    logic                      req_low_seen_q;
    logic                      req_low_seen_d;
    logic                      loaded_q;
    logic                      loaded_d;

    // Output registers
    logic                      status_drive_q;
    logic                      status_drive_d;
    logic                      complete_release_q;
    logic                      complete_release_d;
    logic                      chain_out_n_q;
    logic                      chain_out_n_d;
    logic                      user_q;
    logic                      user_d;
    logic                      link_en_q;
    logic                      link_en_d;
    psc_pkg::psc_byte_t        data_q;
    psc_pkg::psc_byte_t        data_d;
    logic                      data_valid_q;
    logic                      data_valid_d;
    logic                      error_q;
    logic                      error_d;

    // Link-domain shifter; it only sees the enable level
    psc_shift u_shift (
        .config_serial_clock (config_serial_clock),
        .serial_config_data  (serial_config_data),
        .link_enable         (link_en_q),
        .byte_q              (link_byte),
        .byte_toggle_q       (link_toggle)
    );

    // Request, status, completion and chain pins and the link toggle pass two flops before use
    always_comb begin
        sync_in                       = '0;
        sync_in[psc_pkg::SY_REQ_N]    = config_request_n;
        sync_in[psc_pkg::SY_STATUS]   = config_status_n_i;
        sync_in[psc_pkg::SY_COMPLETE] = config_complete_i;
        sync_in[psc_pkg::SY_CHAIN_N]  = chain_enable_in_n;
        sync_in[psc_pkg::SY_TOGGLE]   = link_toggle;
    end

    psc_sync #(.W(psc_pkg::SY_W)) u_pin_sync (
        .clk      (clk),
        .async_in (sync_in),
        .sync_out (sync_s)
    );

    // Named views of the synchronised inputs
    assign req_n_s    = sync_s[psc_pkg::SY_REQ_N];
    assign status_s   = sync_s[psc_pkg::SY_STATUS];
    assign complete_s = sync_s[psc_pkg::SY_COMPLETE];
    assign chain_n_s  = sync_s[psc_pkg::SY_CHAIN_N];
    assign toggle_s   = sync_s[psc_pkg::SY_TOGGLE];

    // A toggle change means a stable byte waits in the link register
    assign new_byte = toggle_s != toggle_seen_q;
    assign check    = xor_q ^ link_byte;

    // Sequencer next-state logic
    always_comb begin
        state_d            = state_q;
        por_cnt_d          = por_cnt_q;
        init_cnt_d         = init_cnt_q;
        byte_cnt_d         = byte_cnt_q;
        xor_d              = xor_q;
        toggle_seen_d      = toggle_s;
        req_low_seen_d     = req_low_seen_q;
        loaded_d           = loaded_q;
        status_drive_d     = status_drive_q;
        complete_release_d = complete_release_q;
        chain_out_n_d      = chain_out_n_q;
        user_d             = user_q;
        link_en_d          = link_en_q;
        data_d             = data_q;
        data_valid_d       = 1'b0;
        error_d            = error_q;
        unique case (state_q)
            psc_pkg::ST_POR: begin
                // Status held low, user I/O off, until count expires
                status_drive_d = 1'b1;
                user_d         = 1'b0;
                por_cnt_d      = por_cnt_q + 21'h1;
                if (por_cnt_q ==
                    psc_pkg::POR_CNT_W'(POR_CYCLES - 1)) begin
                    status_drive_d = 1'b0;
                    state_d        = psc_pkg::ST_RESET;
                end
            end
            psc_pkg::ST_RESET: begin
                // Quiet everything; completion held low in reset
                init_cnt_d         = '0;
                byte_cnt_d         = '0;
                xor_d              = '0;
                loaded_d           = 1'b0;
                complete_release_d = 1'b0;
                chain_out_n_d      = 1'b1;
                user_d             = 1'b0;
                link_en_d          = 1'b0;
                if (!req_n_s) begin
                    // Request low keeps reset and pulls status
                    req_low_seen_d = 1'b1;
                    status_drive_d = 1'b1;
                    error_d        = 1'b0;
                end else if (req_low_seen_q) begin
                    // Rising request: let the pull-up raise status
                    status_drive_d = 1'b0;
                    if (status_s && !status_drive_q) begin
                        // Data accepted only once status reads high
                        req_low_seen_d = 1'b0;
                        link_en_d      = 1'b1;
                        state_d        = psc_pkg::ST_CONFIG;
                    end
                end
            end
            psc_pkg::ST_CONFIG: begin
                if (!req_n_s) begin
                    link_en_d = 1'b0;
                    state_d   = psc_pkg::ST_RESET;
                end else if (!status_s) begin
                    // Another device flagged an error: halt
                    link_en_d = 1'b0;
                    state_d   = psc_pkg::ST_RESET;
                end else if (loaded_q && complete_s) begin
                    // Whole chain done together; stop listening
                    link_en_d = 1'b0;
                    state_d   = psc_pkg::ST_INIT;
                end else if (new_byte && !loaded_q && !chain_n_s) begin
                    // Only the enabled device takes bytes
                    data_d       = link_byte;
                    data_valid_d = 1'b1;
                    xor_d        = check;
                    byte_cnt_d   = byte_cnt_q + 5'h01;
                    if (byte_cnt_q == psc_pkg::BYTE_CNT_W'(
                            psc_pkg::STREAM_BYTES - 1)) begin
                        if (check != psc_pkg::CHECK_OK) begin
                            // Corrupt stream: pull status, stop
                            status_drive_d = 1'b1;
                            error_d        = 1'b1;
                            link_en_d      = 1'b0;
                            state_d        = psc_pkg::ST_ERROR;
                        end else begin
                            // Release completion, hand on enable
                            loaded_d           = 1'b1;
                            complete_release_d = 1'b1;
                            chain_out_n_d      = 1'b0;
                        end
                    end
                end
            end
            psc_pkg::ST_INIT: begin
                // Initialization runs on the core clock; the user
                // start-up clock is never needed by this path
                if (!req_n_s || !status_s) begin
                    state_d = psc_pkg::ST_RESET;
                end else if (init_cnt_q == psc_pkg::INIT_CNT_W'(
                                 psc_pkg::INIT_CYCLES - 1)) begin
                    user_d  = 1'b1;
                    state_d = psc_pkg::ST_USER;
                end else begin
                    init_cnt_d = init_cnt_q + 9'h001;
                end
            end
            psc_pkg::ST_USER: begin
                // Only a new request leaves user mode
                if (!req_n_s) begin
                    user_d  = 1'b0;
                    state_d = psc_pkg::ST_RESET;
                end
            end
            psc_pkg::ST_ERROR: begin
                // Hold status low until the host pulls request
                status_drive_d = 1'b1;
                link_en_d      = 1'b0;
                if (!req_n_s) begin
                    req_low_seen_d = 1'b1;
                    state_d        = psc_pkg::ST_RESET;
                end
            end
            default: begin
                state_d = psc_pkg::ST_RESET;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q            <= psc_pkg::ST_POR;
            por_cnt_q          <= '0;
            init_cnt_q         <= '0;
            byte_cnt_q         <= '0;
            xor_q              <= '0;
            toggle_seen_q      <= 1'b0;
            req_low_seen_q     <= 1'b0;
            loaded_q           <= 1'b0;
            status_drive_q     <= 1'b1;
            complete_release_q <= 1'b0;
            chain_out_n_q      <= 1'b1;
            user_q             <= 1'b0;
            link_en_q          <= 1'b0;
            data_q             <= '0;
            data_valid_q       <= 1'b0;
            error_q            <= 1'b0;
        end else begin
            state_q            <= state_d;
            por_cnt_q          <= por_cnt_d;
            init_cnt_q         <= init_cnt_d;
            byte_cnt_q         <= byte_cnt_d;
            xor_q              <= xor_d;
            toggle_seen_q      <= toggle_seen_d;
            req_low_seen_q     <= req_low_seen_d;
            loaded_q           <= loaded_d;
            status_drive_q     <= status_drive_d;
            complete_release_q <= complete_release_d;
            chain_out_n_q      <= chain_out_n_d;
            user_q             <= user_d;
            link_en_q          <= link_en_d;
            data_q             <= data_d;
            data_valid_q       <= data_valid_d;
            error_q            <= error_d;
        end
    end

    // Open-drain pins only ever pull low
    assign config_status_n_o  = 1'b0;
    assign config_status_n_oe = status_drive_q;
    assign config_complete_o  = 1'b0;
    assign config_complete_oe = ~complete_release_q;

    // Registered outputs
    assign chain_enable_out_n = chain_out_n_q;
    assign config_data        = data_q;
    assign config_data_valid  = data_valid_q;
    assign user_io_enable     = user_q;
    assign config_error       = error_q;

endmodule

// *** testbench/psc_loader_assertions.sv ***
module psc_loader_assertions #(
    parameter int unsigned POR_CYCLES = 20
) (
    // Core clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Host side and shared wire levels
    input  wire logic config_request_n,
    input  wire logic config_complete_i,
    // Outputs under watch
    input  wire logic config_status_n_o,
    input  wire logic config_status_n_oe,
    input  wire logic config_complete_o,
    input  wire logic config_complete_oe,
    input  wire logic chain_enable_out_n,
    input  wire logic config_data_valid,
    input  wire logic user_io_enable,
    input  wire logic config_error
);
    logic [21:0] por_cnt_d, por_cnt_q;
    logic [9:0]  cpl_cnt_d, cpl_cnt_q;

    // Saturating, so a long user-mode run never wraps back into range
    always_comb begin
        por_cnt_d = por_cnt_q + {21'h000000, ~&por_cnt_q};
        cpl_cnt_d = 10'h000;
        if (config_complete_i) begin
            cpl_cnt_d = cpl_cnt_q + {9'h000, ~&cpl_cnt_q};
        end
    end

    // Cycles since reset release and since completion went high
    always_ff @(posedge clk) begin
        por_cnt_q <= srst ? 22'h000000 : por_cnt_d;
        cpl_cnt_q <= srst ? 10'h000 : cpl_cnt_d;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Request steps seen by the host
    sequence req_held_low;
        !config_request_n [*6];
    endsequence
    sequence req_released;
        !config_request_n [*3] ##1 config_request_n;
    endsequence

    a_drive_low_only: assert property (!config_status_n_o && !config_complete_o)
        else $error("open-drain output drives high");
    a_por_hold_status: assert property (!config_status_n_oe |-> por_cnt_q >= POR_CYCLES)
        else $error("status released before power-on reset ended");
    a_reset_while_req: assert property (req_held_low |-> config_status_n_oe && !user_io_enable)
        else $error("device left reset while request low");
    a_release_on_rise: assert property (req_released ##0 (por_cnt_q > POR_CYCLES + 2) |-> ##[1:5] (!config_status_n_oe || !config_request_n))
        else $error("status not released after request rose");
    a_data_when_ready: assert property (config_data_valid |-> $past(!config_status_n_oe && !config_error))
        else $error("byte accepted while status held low");
    a_error_pulls: assert property (config_error |-> config_status_n_oe && config_complete_oe)
        else $error("error without status pulled low");
    a_chain_after_load: assert property ($fell(chain_enable_out_n) |-> !config_complete_oe && !config_error)
        else $error("chain enable passed on without a good load");
    a_user_after_init: assert property ($rose(user_io_enable) |-> cpl_cnt_q >= 299 && cpl_cnt_q <= 306)
        else $error("user mode not 299 clocks after completion");
    a_user_lines_free: assert property (user_io_enable |-> !config_complete_oe && !config_status_n_oe)
        else $error("user mode while holding shared lines");
endmodule

// *** testbench/psc_host.sv ***
module psc_host (
    // Core clock for request timing, completion wire level
    input  wire logic clk,
    input  wire logic config_complete,
    // Lines the host drives; no user start-up clock is offered
    output logic      config_request_n,
    output logic      config_serial_clock,
    output logic      serial_config_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Link clock parks low between frames
    initial begin
        config_request_n = 1'b1;
        config_serial_clock = 1'b0;
        serial_config_data = 1'b0;
    end

    // Request steps land just after a core clock edge
    task automatic req_level(input logic lvl);
        @(posedge clk);
        config_request_n <= lvl;
    endtask

    // Data settles in the low phase, sampled on the rising edge
    task automatic link_bit(input logic b);
        serial_config_data = b;
        #16 config_serial_clock = 1'b1;
        #16 config_serial_clock = 1'b0;
    endtask

    // Six lead-in clocks: the first flush a stale link while its enable
    // is still low, the last two carry the enable through its synchroniser
    task automatic send_stream(input psc_pkg::psc_byte_t s[$]);
        int n;
        #21;
        repeat (6) link_bit(~serial_config_data);
        foreach (s[i]) for (int k = 0; k < 8; k++) link_bit(s[i][k]);
        for (n = 0; n < 64 && config_complete !== 1'b1; n++)
            link_bit(~serial_config_data);
        serial_config_data = ~serial_config_data;
    endtask
endmodule

// *** testbench/tb_psc_loader.sv ***
module tb_psc_loader;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned POR_CYCLES = 20;

    logic clk, srst, chain_enable_in_n, st_other, cpl_other, check_on;
    logic config_request_n, config_serial_clock, serial_config_data;
    logic config_status_n_o, config_status_n_oe, config_complete_o;
    logic config_complete_oe, chain_enable_out_n, config_data_valid;
    logic user_io_enable, config_error, st_wire, cpl_wire;
    psc_pkg::psc_byte_t config_data;
    psc_pkg::psc_byte_t exp_q[$], stream[$];
    int err_total, tests_run, seed, n;

    // Pulled-up shared wires; other chain members may pull them
    assign st_wire = !((config_status_n_oe && !config_status_n_o) || st_other);
    assign cpl_wire = !((config_complete_oe && !config_complete_o) || cpl_other);

    always #25 clk = ~clk;

    psc_loader #(.POR_CYCLES(POR_CYCLES)) DUT (
        .clk(clk), .srst(srst), .config_serial_clock(config_serial_clock),
        .serial_config_data(serial_config_data),
        .config_request_n(config_request_n), .config_status_n_i(st_wire),
        .config_status_n_o(config_status_n_o),
        .config_status_n_oe(config_status_n_oe),
        .config_complete_i(cpl_wire), .config_complete_o(config_complete_o),
        .config_complete_oe(config_complete_oe),
        .chain_enable_in_n(chain_enable_in_n),
        .chain_enable_out_n(chain_enable_out_n), .config_data(config_data),
        .config_data_valid(config_data_valid),
        .user_io_enable(user_io_enable), .config_error(config_error));

    psc_host u_host (.clk(clk), .config_complete(cpl_wire),
        .config_request_n(config_request_n),
        .config_serial_clock(config_serial_clock),
        .serial_config_data(serial_config_data));

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One compare task per kind of result
    task automatic check_bit(input string what, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic check_byte(input string what,
                              input psc_pkg::psc_byte_t e,
                              input psc_pkg::psc_byte_t g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_span(input string what, input int lo, hi, g);
        tests_run++;
        if (g < lo || g > hi) begin
            err_total++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, g);
        end
    endtask

    // Sample a little after the edge so registered outputs have landed
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    function automatic logic probe(input int sel);
        case (sel)
            0: return st_wire;
            1: return user_io_enable;
            default: return config_error;
        endcase
    endfunction

    // Bounded wait; running out is a mismatch and ends the run
    task automatic wait_for(input int sel, input logic lvl, input int bound,
                            output int cnt);
        cnt = 0;
        while (probe(sel) !== lvl && cnt < bound) begin
            tick();
            cnt++;
        end
        if (probe(sel) !== lvl) begin
            err_total++;
            $display("[ERR] wait %0d expected %b seen %b", sel, lvl, probe(sel));
            report_and_stop();
        end
    endtask

    // Random stream whose bytes XOR to zero, optionally spoiled
    task automatic build(input logic bad, input logic keep);
        psc_pkg::psc_byte_t x;
        x = psc_pkg::CHECK_OK;
        stream.delete();
        for (int i = 0; i < psc_pkg::STREAM_BYTES - 1; i++) begin
            stream.push_back(8'($random(seed)));
            x ^= stream[i];
        end
        stream.push_back(x ^ {7'h00, bad});
        if (keep) foreach (stream[i]) exp_q.push_back(stream[i]);
    endtask

    // Low-then-high request; reset stage must hold while it is low
    task automatic restart();
        u_host.req_level(1'b0);
        repeat (6) tick();
        check_bit("status_oe in reset", 1'b1, config_status_n_oe);
        check_bit("error cleared", 1'b0, config_error);
        u_host.req_level(1'b1);
        wait_for(0, 1'b1, 40, n);
    endtask

    // Reference model of accepted bytes, compared at every pulse while check_on is set
    always @(posedge clk) begin
        if (!srst && config_data_valid === 1'b1 && check_on) begin
            if (exp_q.size() == 0)
                check_bit("unexpected byte", 1'b0, 1'b1);
            else
                check_byte("config_data", exp_q.pop_front(), config_data);
        end
    end

    // Cuts a hang short
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        chain_enable_in_n = 1'b0;
        st_other = 1'b0;
        cpl_other = 1'b0;
        check_on = 1'b1;
        seed = 32'hB11968D1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        tick();
        check_bit("status_oe at power-on", 1'b1, config_status_n_oe);
        wait_for(0, 1'b1, 40, n);
        check_span("power-on cycles", POR_CYCLES - 2, POR_CYCLES + 4, n);
        check_bit("user io in power-on", 1'b0, user_io_enable);
        // Corrupt stream: error, status pulled, no completion
        restart();
        build(1'b1, 1'b1);
        u_host.send_stream(stream);
        wait_for(2, 1'b1, 20, n);
        check_bit("status_oe on error", 1'b1, config_status_n_oe);
        check_bit("complete_oe on error", 1'b1, config_complete_oe);
        check_span("bytes left", 0, 0, exp_q.size());
        // Another device reports an error mid-stream
        restart();
        check_on = 1'b0;
        build(1'b0, 1'b0);
        fork
            u_host.send_stream(stream);
            begin
                repeat (30) tick();
                st_other <= 1'b1;
            end
        join
        tick();
        check_bit("complete_oe after halt", 1'b1, config_complete_oe);
        check_bit("status_oe after halt", 1'b0, config_status_n_oe);
        st_other <= 1'b0;
        repeat (4) tick();
        check_on = 1'b1;
        // Chain enable high: nothing may be loaded
        chain_enable_in_n <= 1'b1;
        restart();
        build(1'b0, 1'b0);
        u_host.send_stream(stream);
        check_bit("complete_oe disabled", 1'b1, config_complete_oe);
        check_bit("chain out disabled", 1'b1, chain_enable_out_n);
        repeat (4) tick(); // Last link byte event must pass first
        chain_enable_in_n <= 1'b0;
        // Good load while a chain partner still holds completion low
        restart();
        build(1'b0, 1'b1);
        cpl_other <= 1'b1;
        u_host.send_stream(stream);
        check_span("bytes left", 0, 0, exp_q.size());
        check_bit("complete_oe released", 1'b0, config_complete_oe);
        check_bit("chain out passed on", 1'b0, chain_enable_out_n);
        repeat (10) tick();
        check_bit("user io waits", 1'b0, user_io_enable);
        cpl_other <= 1'b0;
        wait_for(1, 1'b1, 400, n);
        check_span("init cycles", 300, 306, n);
        check_bit("status free in user", 1'b0, config_status_n_oe);
        report_and_stop();
    end
endmodule

bind psc_loader psc_loader_assertions #(.POR_CYCLES(POR_CYCLES)) u_chk (
    .clk(clk), .srst(srst), .config_request_n(config_request_n),
    .config_complete_i(config_complete_i),
    .config_status_n_o(config_status_n_o),
    .config_status_n_oe(config_status_n_oe),
    .config_complete_o(config_complete_o),
    .config_complete_oe(config_complete_oe),
    .chain_enable_out_n(chain_enable_out_n),
    .config_data_valid(config_data_valid),
    .user_io_enable(user_io_enable), .config_error(config_error));
